// >>> hw/load_string_reserve_unit.sv
// execution sequencer for string loads and the reserving word load
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "ldstr_defines.svh"
module load_string_reserve_unit
   import ldstr_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // issue
   input  wire logic        issue_valid_i,
   input  wire logic [31:0] instr_i,
   input  wire logic [31:0] base_data_i,
   input  wire logic [31:0] index_data_i,
   input  wire logic [6:0]  transfer_byte_count_field_i,
   input  wire logic        abort_i,
   input  wire logic        cond_store_done_i,
   output logic             busy_o,
   output logic             done_o,
   // storage access
   output logic             mem_req_o,
   output logic [31:0]      mem_addr_o,
   output logic             mem_word_o,
   input  wire logic        mem_ack_i,
   input  wire logic [31:0] mem_data_i,
   output logic             exc_suppress_o,
   // register write port
   output logic             gpr_we_o,
   output logic [4:0]       gpr_addr_o,
   output logic [31:0]      gpr_data_o,
   output logic             reserve_o
);
   typedef struct packed {
      seq_state_t  st;
      op_kind_t    op;
      logic [31:0] addr;
      logic [6:0]  remain;
      logic [1:0]  lane;
      logic [4:0]  rnum;
      logic [31:0] acc;
      logic        req;
      logic        wordacc;
      logic        we;
      logic [4:0]  wa;
      logic [31:0] wd;
      logic        rsv;
      logic        done;
      logic        supp;
   } state_t;

   state_t s_reg;
   state_t s_next;
   logic [31:0] packed_word;
   logic [7:0]  mem_byte;

   wire logic [5:0] opc   = instr_i[31:26];
   wire logic [4:0] tgt   = instr_i[25:21];
   wire logic [4:0] basef = instr_i[20:16];
   wire logic [4:0] nbf   = instr_i[15:11];
   wire logic [9:0] xo    = instr_i[10:1];
   wire logic [31:0] base_or_zero = (basef == 5'h0) ? 32'h0 : base_data_i;

   // lane select of the addressed byte in a big-endian word
   assign mem_byte = mem_data_i[8'(31 - 8 * s_reg.addr[1:0]) -: 8];

   byte_packer u_pack (
      .word_i (s_reg.acc),
      .lane_i (s_reg.lane),
      .byte_i (mem_byte),
      .word_o (packed_word)
   );

   always_comb begin
      s_next      = s_reg;
      s_next.we   = 1'b0;
      s_next.done = 1'b0;
      s_next.supp = 1'b0;
      if (cond_store_done_i) begin
         s_next.rsv = 1'b0;
      end
      unique case (s_reg.st)
         ST_IDLE: begin
            if (issue_valid_i && opc == `OPC_PRIMARY) begin
               if (xo == `XO_STR_IMM) begin
                  s_next.addr   = base_or_zero;
                  s_next.remain = (nbf == 5'h0) ? `FULL_COUNT : {2'h0, nbf};
                  s_next.op     = OP_STR;
                  s_next.lane   = 2'h0;
                  s_next.rnum   = tgt;
                  s_next.acc    = 32'h0;
                  s_next.req    = 1'b1;
                  s_next.wordacc = 1'b0;
                  s_next.st     = ST_REQ;
               end else if (xo == `XO_STR_IDX) begin
                  s_next.addr   = base_or_zero + index_data_i;
                  s_next.remain = transfer_byte_count_field_i;
                  s_next.op     = OP_STR;
                  s_next.lane   = 2'h0;
                  s_next.rnum   = tgt;
                  s_next.acc    = 32'h0;
                  s_next.wordacc = 1'b0;
                  if (transfer_byte_count_field_i == 7'h0) begin
                     // no access, so no exception can be raised
                     s_next.supp = 1'b1;
                     s_next.st   = ST_DONE;
                  end else begin
                     s_next.req = 1'b1;
                     s_next.st  = ST_REQ;
                  end
               end else if (xo == `XO_LOAD_RESERVE) begin
                  s_next.addr    = base_or_zero + index_data_i;
                  s_next.op      = OP_RSV;
                  s_next.rnum    = tgt;
                  s_next.req     = 1'b1;
                  s_next.wordacc = 1'b1;
                  s_next.st      = ST_REQ;
               end
            end
         end
         ST_REQ, ST_WAIT: begin
            s_next.st = ST_WAIT;
            if (abort_i) begin
               // interrupted: restart later from the first byte
               s_next.req = 1'b0;
               s_next.st  = ST_DONE;
            end else if (mem_ack_i && s_reg.op == OP_RSV) begin
               s_next.req = 1'b0;
               s_next.we  = 1'b1;
               s_next.wa  = s_reg.rnum;
               s_next.wd  = mem_data_i;
               s_next.rsv = 1'b1;
               s_next.st  = ST_DONE;
            end else if (mem_ack_i) begin
               s_next.acc    = packed_word;
               s_next.remain = s_reg.remain - 7'h1;
               s_next.addr   = s_reg.addr + 32'h1;
               s_next.lane   = s_reg.lane + 2'h1;
               if (s_reg.lane == 2'h3 || s_reg.remain == 7'h1) begin
                  s_next.we   = 1'b1;
                  s_next.wa   = s_reg.rnum;
                  s_next.wd   = packed_word;
                  s_next.rnum = s_reg.rnum + 5'h1;
                  s_next.lane = 2'h0;
               end
               if (s_reg.remain == 7'h1) begin
                  s_next.req = 1'b0;
                  s_next.st  = ST_DONE;
               end
            end
         end
         ST_DONE: begin
            s_next.done = 1'b1;
            s_next.op   = OP_NONE;
            s_next.st   = ST_IDLE;
         end
         default: s_next.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_reg    <= '0;
         s_reg.st <= ST_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   // condition field zero is never written by this unit
   assign busy_o         = (s_reg.st != ST_IDLE);
   assign done_o         = s_reg.done;
   assign mem_req_o      = s_reg.req;
   assign mem_addr_o     = s_reg.addr;
   assign mem_word_o     = s_reg.wordacc;
   assign exc_suppress_o = s_reg.supp;
   assign gpr_we_o       = s_reg.we;
   assign gpr_addr_o     = s_reg.wa;
   assign gpr_data_o     = s_reg.wd;
   assign reserve_o      = s_reg.rsv;

   rsv_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_reg.st == ST_WAIT && s_reg.op == OP_RSV && mem_ack_i && !abort_i)
      |=> reserve_o && gpr_we_o && gpr_data_o == $past(mem_data_i))
      else $error("reserving load did not set flag");
   rsv_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cond_store_done_i && !(mem_ack_i && s_reg.op == OP_RSV) |=> !reserve_o)
      else $error("conditional store did not clear flag");
   zero_cnt_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_reg.st == ST_IDLE && issue_valid_i && opc == `OPC_PRIMARY
       && xo == `XO_STR_IDX && transfer_byte_count_field_i == 7'h0)
      |=> !mem_req_o && exc_suppress_o ##1 done_o && !mem_req_o)
      else $error("zero count indexed load accessed storage");
   imm_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_reg.st == ST_IDLE && issue_valid_i && opc == `OPC_PRIMARY
       && xo == `XO_STR_IMM && basef == 5'h0) |=> mem_addr_o == 32'h0)
      else $error("immediate string address not zero");
   imm_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_reg.st == ST_IDLE && issue_valid_i && opc == `OPC_PRIMARY
       && xo == `XO_STR_IMM && nbf == 5'h0) |=> s_reg.remain == `FULL_COUNT)
      else $error("zero count field not full count");
   idx_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_reg.st == ST_IDLE && issue_valid_i && opc == `OPC_PRIMARY
       && xo == `XO_LOAD_RESERVE)
      |=> mem_addr_o == $past(base_or_zero) + $past(index_data_i))
      else $error("indexed address wrong");
   wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
      gpr_we_o && s_reg.op == OP_STR && s_reg.st != ST_DONE
      && gpr_addr_o == `LAST_REG |-> s_reg.rnum == 5'h0)
      else $error("register number did not wrap");
   tail_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_reg.op == OP_STR && mem_ack_i && !abort_i && s_reg.remain == 7'h1
       && s_reg.lane == 2'h0) |=> gpr_we_o && gpr_data_o[23:0] == 24'h0)
      else $error("bits right of last byte not cleared");
   abort_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_reg.st == ST_REQ || s_reg.st == ST_WAIT) && abort_i
      |=> !mem_req_o && !gpr_we_o)
      else $error("abort did not stop the load");
   word_acc_a: assert property (@(posedge clk_i) disable iff (rst_i)
      mem_req_o && s_reg.op == OP_RSV |-> mem_word_o)
      else $error("reserving load not a word access");
   busy_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      mem_req_o |-> busy_o && !done_o)
      else $error("done while access outstanding");
endmodule // load_string_reserve_unit
`default_nettype wire

// >>> hw/ldstr_defines.svh
// constants for the string load and reserving load unit
// Functional notes
// - immediate string: address is base or zero
// - count field zero means 32 bytes
// - four bytes per register, lowest address leftmost
// - bits right of last byte cleared
// - registers from target upward, wrap after 31
// - indexed forms: index plus base or zero
// - indexed string count from exception register
// - indexed zero count: no access, no-op
// - zero count suppresses storage and debug exceptions
// - condition field zero left undefined
// - interrupted string load restarts from first byte
// - reserving load reads word into target
// - reserving load sets reservation flag
// - only reserving load sets; conditional store clears
`ifndef LDSTR_DEFINES_SVH
`define LDSTR_DEFINES_SVH
`define OPC_PRIMARY       6'h1f
`define XO_STR_IMM        10'h255
`define XO_STR_IDX        10'h215
`define XO_LOAD_RESERVE   10'h014
`define FULL_COUNT        7'h20
`define BYTES_PER_REG     3'h4
`define LAST_REG          5'h1f
`endif

// >>> hw/ldstr_pkg.sv
// types for the string load and reserving load unit
package ldstr_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_REQ  = 4'h2,
      ST_WAIT = 4'h4,
      ST_DONE = 4'h8
   } seq_state_t;
   typedef enum logic [1:0] {
      OP_NONE = 2'h0,
      OP_STR  = 2'h1,
      OP_RSV  = 2'h2
   } op_kind_t;
endpackage

// >>> hw/byte_packer.sv
// places one loaded byte into the assembly word
`timescale 1ns/1ns
`default_nettype none
module byte_packer (
   // assembly word in and out
   input  wire logic [31:0] word_i,
   input  wire logic [1:0]  lane_i,
   input  wire logic [7:0]  byte_i,
   output logic      [31:0] word_o
);
   // lane 0 is the most significant byte; lanes right of it are zero
   always_comb begin
      word_o = 32'h0;
      unique case (lane_i)
         2'h0: word_o = {byte_i, 24'h0};
         2'h1: word_o = {word_i[31:24], byte_i, 16'h0};
         2'h2: word_o = {word_i[31:16], byte_i, 8'h0};
         2'h3: word_o = {word_i[31:8], byte_i};
      endcase
   end
endmodule // byte_packer
`default_nettype wire

// >>> bench/mem_model.sv
// storage path model: big-endian byte memory with a variable ack delay
`timescale 1ns/1ns
`default_nettype none
module mem_model (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // access
   input  wire logic        req_i,
   input  wire logic [31:0] addr_i,
   input  wire logic        slow_i,
   output logic             ack_o,
   output logic [31:0]      data_o
);
   logic [1:0]  wait_reg;
   logic [31:0] a;
   function automatic logic [7:0] byte_at(input logic [31:0] x);
      return x[7:0] ^ x[15:8] ^ 8'h3c;
   endfunction
   assign a = {addr_i[31:2], 2'h0};
   always_ff @(posedge clk_i) begin
      if (rst_i || ack_o || !req_i) begin
         ack_o <= 1'b0;
         wait_reg <= slow_i ? 2'h3 : 2'h0;
         // no stale data outside an ack
         data_o <= rst_i ? 32'h5a0f_c3a5 : ~data_o;
      end else if (wait_reg != 2'h0) begin
         wait_reg <= wait_reg - 2'h1;
         data_o <= ~data_o;
      end else begin
         ack_o <= 1'b1;
         // lowest address in bits 31:24
         data_o <= {byte_at(a), byte_at(a + 1), byte_at(a + 2), byte_at(a + 3)};
      end
   end
endmodule // mem_model
`default_nettype wire

// >>> bench/tb.sv
// self-checking bench for the string load and reserving load unit
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clk_i = 0, rst_i = 1, issue_valid_i = 0, abort_i = 0, cond_store_done_i = 0, slow = 0;
   logic [31:0] instr_i = 32'h0, base_data_i = 32'h0, index_data_i = 32'h0, b, x;
   logic [6:0]  transfer_byte_count_field_i = 7'h0;
   logic        busy_o, done_o, mem_req_o, mem_word_o, mem_ack_i, exc_suppress_o;
   logic        gpr_we_o, reserve_o;
   logic [31:0] mem_addr_o, mem_data_i, gpr_data_o;
   logic [4:0]  gpr_addr_o, rt;
   logic [36:0] wr_q[$];
   logic [31:0] ad_q[$];
   int error_cnt = 0, num_checks = 0, cyc = 0, exc_cnt = 0, c;
   load_string_reserve_unit load_string_reserve_unit_inst (.clk_i, .rst_i, .issue_valid_i,
      .instr_i, .base_data_i, .index_data_i, .transfer_byte_count_field_i, .abort_i,
      .cond_store_done_i, .busy_o, .done_o, .mem_req_o, .mem_addr_o, .mem_word_o, .mem_ack_i,
      .mem_data_i, .exc_suppress_o, .gpr_we_o, .gpr_addr_o, .gpr_data_o, .reserve_o);
   mem_model mem_model_inst (.clk_i, .rst_i, .req_i(mem_req_o), .addr_i(mem_addr_o),
      .slow_i(slow), .ack_o(mem_ack_i), .data_o(mem_data_i));
   initial forever #20 clk_i = ~clk_i;
   task automatic chk(input logic [36:0] e, input logic [36:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic give_verdict;
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         give_verdict();
      end
      if (exc_suppress_o) exc_cnt++;
      if (gpr_we_o)
         chk(wr_q.size() ? wr_q.pop_front() : 'x, {gpr_addr_o, gpr_data_o});
      if (mem_req_o && mem_ack_i)
         chk(ad_q.size() ? ad_q.pop_front() : 'x, 37'(mem_addr_o));
   end
   // byte-wise expectations: addresses and packed register writes
   task automatic expect_str(input logic [4:0] r, input logic [31:0] ea, input int n);
      logic [31:0] w = 32'h0;
      for (int k = 0; k < n; k++) begin
         ad_q.push_back(ea + k);
         w[31 - 8 * (k % 4) -: 8] = mem_model_inst.byte_at(ea + k);
         if (k % 4 == 3 || k == n - 1) begin
            wr_q.push_back({r, w});
            r++;
            w = 32'h0;
         end
      end
   endtask
   task automatic issue(input logic [9:0] xo, input logic [4:0] t, a, f, input logic [31:0] bd, xd);
      int n = 0;
      @(posedge clk_i);
      issue_valid_i <= 1'b1;
      instr_i <= {6'h1f, t, a, f, xo, 1'($urandom)};
      base_data_i <= bd;
      index_data_i <= xd;
      slow <= 1'($urandom);
      @(posedge clk_i);
      // a second offer while busy must be ignored
      instr_i <= {6'h1f, 15'h0, 10'h014, 1'b0};
      @(posedge clk_i);
      issue_valid_i <= 1'b0;
      while (done_o !== 1'b1 && n < 1000) begin
         @(posedge clk_i);
         n++;
      end
      if (n == 1000) error_cnt++;
   endtask
   initial begin
      void'($urandom(6475));
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk(37'h0, 37'({busy_o, reserve_o, done_o, mem_req_o, gpr_we_o}));
      expect_str(5'h1e, 32'h0, 32);
      issue(10'h255, 5'h1e, 5'h0, 5'h0, 32'h1234_5678, 32'h40);
      for (int i = 0; i < 24; i++) begin
         rt = 5'($urandom);
         b = $urandom;
         x = $urandom;
         c = i[0] ? $urandom_range(100, 1) : $urandom_range(31, 1);
         transfer_byte_count_field_i <= i[0] ? 7'(c) : 7'($urandom);
         if (i[0]) expect_str(rt, (rt == 5'h1 ? 32'h0 : b) + x, c);
         else expect_str(rt, rt == 5'h1 ? 32'h0 : b, c);
         if (i[0]) issue(10'h215, rt, rt - 5'h1, rt - 5'h2, b, x);
         else issue(10'h255, rt, rt - 5'h1, 5'(c), b, x);
      end
      transfer_byte_count_field_i <= 7'h0;
      issue(10'h215, 5'h5, 5'h3, 5'h4, 32'h100, 32'h8);
      chk(37'h1, 37'(exc_cnt));
      // interrupted string load writes nothing, then restarts from its first byte
      abort_i <= 1'b1;
      issue(10'h255, 5'h3, 5'h0, 5'h8, 32'h0, 32'h0);
      abort_i <= 1'b0;
      expect_str(5'h3, 32'h0, 8);
      issue(10'h255, 5'h3, 5'h0, 5'h8, 32'h0, 32'h0);
      b = $urandom & 32'hffff_fff0;
      x = 32'h24;
      expect_str(5'h9, b + x, 4);
      expect_str(5'h2, x, 4);
      // word loads make one access each, at the word address
      ad_q.delete();
      ad_q.push_back(b + x);
      ad_q.push_back(x);
      issue(10'h014, 5'h9, 5'h7, 5'h8, b, x);
      issue(10'h014, 5'h2, 5'h0, 5'h8, b, x);
      chk(37'h1, 37'(reserve_o));
      cond_store_done_i <= 1'b1;
      @(posedge clk_i);
      cond_store_done_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk(37'h0, 37'(reserve_o));
      chk(37'h0, 37'(wr_q.size() + ad_q.size()));
      give_verdict();
   end
endmodule // tb
`default_nettype wire
